// ### exchanger_pkg.sv
// Constants shared by the registered bus exchanger, its capture log and its APB slave.
// Assumes a single 200 MHz clock, core_clk, and an APB master with 32-bit data.
package exchanger_pkg;
  localparam int unsigned NARROW_W = 12;
  localparam int unsigned LOG_DEPTH = 32;
  localparam int unsigned LEVEL_W = 6;
  localparam int unsigned APB_AW = 8;

  // Register byte addresses
  localparam logic [APB_AW-1:0] CTRL_ADDR = 8'h00;
  localparam logic [APB_AW-1:0] STATUS_ADDR = 8'h04;
  localparam logic [APB_AW-1:0] LOG_ADDR = 8'h08;

  // Field positions
  localparam int unsigned CTRL_LOG_EN_BIT = 0;
  localparam int unsigned STAT_OVERFLOW_BIT = 0;
  localparam int unsigned STAT_LOG_VALID_BIT = 1;
  localparam int unsigned STAT_NARROW_OE_BIT = 4;
  localparam int unsigned STAT_FIRST_OE_BIT = 5;
  localparam int unsigned STAT_SECOND_OE_BIT = 6;
  localparam int unsigned STAT_LEVEL_LSB = 8;

  localparam logic CTRL_LOG_EN_RESET = 1'b0;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
endpackage

// ### exchanger_log_mem.sv
// Small word memory for the capture log, read data from a register.
// Assumes one write and one read port on the same clock.
`timescale 1ns/1ps
module exchanger_log_mem #(
  parameter int unsigned WIDTH = 12,
  parameter int unsigned DEPTH = 32
) (
  input wire logic core_clk, // Clock
  input wire logic wr_en, // Write strobe
  input wire logic [$clog2(DEPTH)-1:0] wr_addr, // Write address
  input wire logic [WIDTH-1:0] wr_data, // Write data
  input wire logic [$clog2(DEPTH)-1:0] rd_addr, // Read address
  output logic [WIDTH-1:0] rd_data_q // Registered read data
);
  logic [WIDTH-1:0] mem_q [DEPTH];

  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  // Write-through so a word pushed into an empty log is seen at once
  always_ff @(posedge core_clk) begin
    if (wr_en && (wr_addr == rd_addr)) begin
      rd_data_q <= wr_data;
    end else begin
      rd_data_q <= mem_q[rd_addr];
    end
  end
endmodule

// ### exchanger_log_fifo.sv
// First-in first-out buffer for captured narrow words, valid and ready on both sides.
// Assumes synchronous active-high reset; read data are valid while out_valid is high.
`timescale 1ns/1ps
module exchanger_log_fifo #(
  parameter int unsigned WIDTH = 12,
  parameter int unsigned DEPTH = 32
) (
  input wire logic core_clk, // Clock
  input wire logic rst, // Synchronous reset
  input wire logic in_valid, // Push request
  output logic in_ready, // Room for a word
  input wire logic [WIDTH-1:0] in_data, // Pushed word
  output logic out_valid, // Word available
  input wire logic out_ready, // Pop request
  output logic [WIDTH-1:0] out_data, // Oldest word
  output logic [$clog2(DEPTH):0] level // Words held
);
  localparam int unsigned PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL_COUNT = (PW+1)'(DEPTH);
  logic [PW-1:0] wr_ptr_q;
  logic [PW-1:0] rd_ptr_q;
  logic [PW:0] count_q;
  logic push;
  logic pop;

  assign in_ready = (count_q != FULL_COUNT);
  assign out_valid = (count_q != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign level = count_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

  // Read address runs one ahead on a pop so the registered data keep up
  exchanger_log_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_mem (
    .core_clk(core_clk),
    .wr_en(push),
    .wr_addr(wr_ptr_q),
    .wr_data(in_data),
    .rd_addr(pop ? rd_ptr_q + 1'b1 : rd_ptr_q),
    .rd_data_q(out_data)
  );
endmodule

// ### bus_exchanger.sv
// Registered 12-bit to 24-bit bus exchanger with three-state pins and an APB capture log.
// Assumes pins synchronous to core_clk; a testbench resolves pins from the enables.
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/1ps
module bus_exchanger (
  input wire logic core_clk, // 200 MHz clock
  input wire logic rst, // Synchronous reset, drive enables and bus side
  input wire logic [exchanger_pkg::NARROW_W-1:0] narrow_in, // Narrow pin level
  output logic [exchanger_pkg::NARROW_W-1:0] narrow_out, // Narrow pin drive value
  output logic narrow_oe, // Narrow pin driven
  input wire logic [exchanger_pkg::NARROW_W-1:0] first_wide_half_in, // First half pin level
  output logic [exchanger_pkg::NARROW_W-1:0] first_wide_half_out, // First half drive value
  output logic first_wide_half_oe, // First half driven
  input wire logic [exchanger_pkg::NARROW_W-1:0] second_wide_half_in, // Second half level
  output logic [exchanger_pkg::NARROW_W-1:0] second_wide_half_out, // Second half value
  output logic second_wide_half_oe, // Second half driven
  input wire logic first_half_load_enable_n, // Load first half, low
  input wire logic second_half_load_enable_n, // Load second half, low
  input wire logic half_select_n, // High picks first half
  input wire logic narrow_port_drive_enable_n, // Narrow drive, low
  input wire logic first_half_drive_enable_n, // First half drive, low
  input wire logic second_half_drive_enable_n, // Second half drive, low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [exchanger_pkg::APB_AW-1:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr // APB error
);
  localparam int unsigned W = exchanger_pkg::NARROW_W;
  localparam int unsigned LW = exchanger_pkg::LEVEL_W;

  logic [W-1:0] first_half_q;
  logic [W-1:0] second_half_q;
  logic [W-1:0] narrow_q;
  logic [W-1:0] narrow_d;
  logic narrow_oe_q;
  logic first_oe_q;
  logic second_oe_q;
  logic log_en_q;
  logic overflow_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic log_ready;
  logic log_valid;
  logic [W-1:0] log_data;
  logic [LW-1:0] log_level;
  logic bus_access;
  logic bus_done;
  logic addr_hit;
  logic log_pop;
  logic [31:0] status_word;

  //////////////////////////////////////////////////////////////////////////////
  // Pin side. Data registers carry no reset on purpose.

  always_ff @(posedge core_clk) begin
    if (!first_half_load_enable_n) begin
      first_half_q <= narrow_in;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!second_half_load_enable_n) begin
      second_half_q <= narrow_in;
    end
  end

  // Single wide-to-narrow register, loaded on every edge
  assign narrow_d = half_select_n ? first_wide_half_in : second_wide_half_in;

  always_ff @(posedge core_clk) begin
    narrow_q <= narrow_d;
  end

  // Drive state comes up floating under reset, then follows the sampled enables
  always_ff @(posedge core_clk) begin
    if (rst) begin
      narrow_oe_q <= 1'b0;
      first_oe_q <= 1'b0;
      second_oe_q <= 1'b0;
    end else begin
      narrow_oe_q <= !narrow_port_drive_enable_n;
      first_oe_q <= !first_half_drive_enable_n;
      second_oe_q <= !second_half_drive_enable_n;
    end
  end

  assign narrow_out = narrow_q;
  assign narrow_oe = narrow_oe_q;
  assign first_wide_half_out = first_half_q;
  assign first_wide_half_oe = first_oe_q;
  assign second_wide_half_out = second_half_q;
  assign second_wide_half_oe = second_oe_q;

  //////////////////////////////////////////////////////////////////////////////
  // Capture log. A full log drops the word and raises overflow; the pins never stall.

  exchanger_log_fifo #(.WIDTH(W), .DEPTH(exchanger_pkg::LOG_DEPTH)) u_log (
    .core_clk(core_clk),
    .rst(rst),
    .in_valid(log_en_q),
    .in_ready(log_ready),
    .in_data(narrow_d),
    .out_valid(log_valid),
    .out_ready(log_pop),
    .out_data(log_data),
    .level(log_level)
  );

  //////////////////////////////////////////////////////////////////////////////
  // APB slave, one wait state on every access

  assign bus_access = psel && penable && !pready_q;
  assign bus_done = psel && penable && pready_q;
  assign addr_hit = (paddr == exchanger_pkg::CTRL_ADDR) ||
                    (paddr == exchanger_pkg::STATUS_ADDR) ||
                    (paddr == exchanger_pkg::LOG_ADDR);
  assign log_pop = bus_done && !pwrite && (paddr == exchanger_pkg::LOG_ADDR) && log_valid;

  always_comb begin
    status_word = exchanger_pkg::ZERO_WORD;
    status_word[exchanger_pkg::STAT_OVERFLOW_BIT] = overflow_q;
    status_word[exchanger_pkg::STAT_LOG_VALID_BIT] = log_valid;
    status_word[exchanger_pkg::STAT_NARROW_OE_BIT] = narrow_oe_q;
    status_word[exchanger_pkg::STAT_FIRST_OE_BIT] = first_oe_q;
    status_word[exchanger_pkg::STAT_SECOND_OE_BIT] = second_oe_q;
    status_word[exchanger_pkg::STAT_LEVEL_LSB +: LW] = log_level;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= exchanger_pkg::ZERO_WORD;
    end else begin
      pready_q <= bus_access;
      pslverr_q <= bus_access && !addr_hit;
      prdata_q <= exchanger_pkg::ZERO_WORD;
      if (bus_access && !pwrite) begin
        case (paddr)
          exchanger_pkg::CTRL_ADDR: begin
            prdata_q[exchanger_pkg::CTRL_LOG_EN_BIT] <= log_en_q;
          end
          exchanger_pkg::STATUS_ADDR: begin
            prdata_q <= status_word;
          end
          exchanger_pkg::LOG_ADDR: begin
            prdata_q[W-1:0] <= log_valid ? log_data : '0;
          end
          default: begin
            prdata_q <= exchanger_pkg::ZERO_WORD;
          end
        endcase
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      log_en_q <= exchanger_pkg::CTRL_LOG_EN_RESET;
    end else if (bus_done && pwrite && (paddr == exchanger_pkg::CTRL_ADDR)) begin
      log_en_q <= pwdata[exchanger_pkg::CTRL_LOG_EN_BIT];
    end
  end

  // A lost word in the clearing cycle keeps the flag set
  always_ff @(posedge core_clk) begin
    if (rst) begin
      overflow_q <= 1'b0;
    end else if (log_en_q && !log_ready) begin
      overflow_q <= 1'b1;
    end else if (bus_done && pwrite && (paddr == exchanger_pkg::STATUS_ADDR) &&
                 pwdata[exchanger_pkg::STAT_OVERFLOW_BIT]) begin
      overflow_q <= 1'b0;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  chk_first_load: assert property (@(posedge core_clk) disable iff (rst)
    !first_half_load_enable_n |=> first_wide_half_out == $past(narrow_in))
    else $error("first half missed its load");

  chk_second_load: assert property (@(posedge core_clk) disable iff (rst)
    !second_half_load_enable_n |=> second_wide_half_out == $past(narrow_in))
    else $error("second half missed its load");

  chk_halves_hold: assert property (@(posedge core_clk) disable iff (rst)
    first_half_load_enable_n && second_half_load_enable_n |=>
      $stable(first_wide_half_out) && $stable(second_wide_half_out))
    else $error("wide half changed without a load");

  chk_select_first: assert property (@(posedge core_clk) disable iff (rst)
    half_select_n |=> narrow_out == $past(first_wide_half_in))
    else $error("narrow register did not take first half");

  chk_select_second: assert property (@(posedge core_clk) disable iff (rst)
    !half_select_n |=> narrow_out == $past(second_wide_half_in))
    else $error("narrow register did not take second half");

  chk_narrow_drive: assert property (@(posedge core_clk) disable iff (rst)
    ##1 narrow_oe == !$past(narrow_port_drive_enable_n))
    else $error("narrow drive does not follow its enable");

  chk_half_drive: assert property (@(posedge core_clk) disable iff (rst)
    ##1 (first_wide_half_oe == !$past(first_half_drive_enable_n)) &&
        (second_wide_half_oe == !$past(second_half_drive_enable_n)))
    else $error("wide drive does not follow its enable");

  chk_reset_float: assert property (@(posedge core_clk)
    rst |=> !narrow_oe && !first_wide_half_oe && !second_wide_half_oe)
    else $error("a pin drives right after reset");

  chk_bus_answer: assert property (@(posedge core_clk) disable iff (rst)
    psel && !penable ##1 psel && penable |-> !pready ##1 pready)
    else $error("APB answer not after one wait state");

  chk_first_hold: assert property (@(posedge core_clk) disable iff (rst)
    first_half_load_enable_n |=> $stable(first_wide_half_out))
    else $error("first half changed without its load");

  chk_second_hold: assert property (@(posedge core_clk) disable iff (rst)
    second_half_load_enable_n |=> $stable(second_wide_half_out))
    else $error("second half changed without its load");

  chk_overflow_set: assert property (@(posedge core_clk) disable iff (rst)
    log_en_q && !log_ready |=> overflow_q)
    else $error("dropped log word did not raise overflow");

  chk_overflow_sticky: assert property (@(posedge core_clk) disable iff (rst)
    overflow_q && !(bus_done && pwrite && (paddr == exchanger_pkg::STATUS_ADDR)) |=>
      overflow_q)
    else $error("overflow cleared without a status write");

  chk_overflow_clear: assert property (@(posedge core_clk) disable iff (rst)
    bus_done && pwrite && (paddr == exchanger_pkg::STATUS_ADDR) &&
      pwdata[exchanger_pkg::STAT_OVERFLOW_BIT] && !(log_en_q && !log_ready) |=> !overflow_q)
    else $error("overflow not cleared by its write");

  chk_unmapped_error: assert property (@(posedge core_clk) disable iff (rst)
    bus_access && !addr_hit |=> pready && pslverr)
    else $error("unmapped access not answered with an error");

  chk_mapped_quiet: assert property (@(posedge core_clk) disable iff (rst)
    bus_access && addr_hit |=> pready && !pslverr)
    else $error("mapped access answered with an error");

  chk_error_with_ready: assert property (@(posedge core_clk) disable iff (rst)
    pslverr |-> pready)
    else $error("error shown without ready");

  chk_ready_pulse: assert property (@(posedge core_clk) disable iff (rst)
    pready |=> !pready)
    else $error("ready stood longer than one cycle");

  chk_log_read_data: assert property (@(posedge core_clk) disable iff (rst)
    bus_access && !pwrite && (paddr == exchanger_pkg::LOG_ADDR) && log_valid |=>
      prdata == 32'($past(log_data)))
    else $error("log read did not return the oldest word");

  chk_empty_log_read: assert property (@(posedge core_clk) disable iff (rst)
    bus_access && !pwrite && (paddr == exchanger_pkg::LOG_ADDR) && !log_valid |=>
      prdata == exchanger_pkg::ZERO_WORD)
    else $error("empty log read not zero");

  chk_write_reads_zero: assert property (@(posedge core_clk) disable iff (rst)
    bus_access && pwrite |=> prdata == exchanger_pkg::ZERO_WORD)
    else $error("read data not zero on a write");

  chk_ctrl_write: assert property (@(posedge core_clk) disable iff (rst)
    bus_done && pwrite && (paddr == exchanger_pkg::CTRL_ADDR) |=>
      log_en_q == $past(pwdata[exchanger_pkg::CTRL_LOG_EN_BIT]))
    else $error("log enable did not take the written bit");

  chk_ctrl_read: assert property (@(posedge core_clk) disable iff (rst)
    bus_access && !pwrite && (paddr == exchanger_pkg::CTRL_ADDR) |=>
      prdata[exchanger_pkg::CTRL_LOG_EN_BIT] == $past(log_en_q))
    else $error("control read does not show log enable");

  chk_status_read: assert property (@(posedge core_clk) disable iff (rst)
    bus_access && !pwrite && (paddr == exchanger_pkg::STATUS_ADDR) |=>
      prdata == $past(status_word))
    else $error("status read does not match the flags");

  chk_log_full: assert property (@(posedge core_clk) disable iff (rst)
    log_ready != (log_level == exchanger_pkg::LOG_DEPTH))
    else $error("log room does not match its level");

  chk_log_push: assert property (@(posedge core_clk) disable iff (rst)
    log_en_q && log_ready && !log_pop |=>
      log_level == $past(log_level) + 1'b1)
    else $error("log level did not grow on a push");

  chk_log_pop: assert property (@(posedge core_clk) disable iff (rst)
    log_pop && !(log_en_q && log_ready) |=>
      log_level == $past(log_level) - 1'b1)
    else $error("log level did not shrink on a pop");

  chk_reset_bus: assert property (@(posedge core_clk)
    rst |=> !pready && !pslverr && !log_valid && !log_en_q && !overflow_q)
    else $error("bus side not quiet after reset");
endmodule

// ### dram_side_model.sv
// Far-side model of the wide bus: presents its own words on each half.
// Assumes the bench supplies the words; backs off while the exchanger drives.
`timescale 1ns/1ps
module dram_side_model (
  input wire logic [11:0] first_word, // Far-side first half word
  input wire logic [11:0] second_word, // Far-side second half word
  input wire logic first_oe, // Exchanger drives first half
  input wire logic [11:0] first_out, // Exchanger first half value
  input wire logic second_oe, // Exchanger drives second half
  input wire logic [11:0] second_out, // Exchanger second half value
  output logic [11:0] first_level, // Resolved first half
  output logic [11:0] second_level // Resolved second half
);
  // Releasing while the exchanger drives avoids contention on the line
  assign first_level = first_oe ? first_out : first_word;
  assign second_level = second_oe ? second_out : second_word;
endmodule

// ### bus_exchanger_tb.sv
// Self-checking bench for the bus exchanger: random pin traffic and the APB capture log.
// Assumes core_clk at 200 MHz and the one-wait-state APB slave of the design.
`timescale 1ns/1ps
module bus_exchanger_tb;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  // Control bits: {ld1_n, ld2_n, sel_n, narrow drive_n, first drive_n, second drive_n}
  logic [5:0] ctl = 6'h0f;
  logic [11:0] narrow_word = 12'h0a1, w1 = 12'h0b2, w2 = 12'h0c3;
  logic [11:0] narrow_in, narrow_out, l1, l2, f_out, s_out, e1, e2, en;
  logic narrow_oe, f_oe, s_oe, pready, pslverr, er;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [31:0] seed = 32'h0001_65bc;
  logic [2:0] eoe;
  int errors = 0;
  int samples_checked = 0;

  always #2.5 core_clk = ~core_clk;
  assign narrow_in = narrow_oe ? narrow_out : narrow_word;

  bus_exchanger dut_u (.core_clk(core_clk), .rst(rst), .narrow_in(narrow_in),
    .narrow_out(narrow_out), .narrow_oe(narrow_oe), .first_wide_half_in(l1),
    .first_wide_half_out(f_out), .first_wide_half_oe(f_oe), .second_wide_half_in(l2),
    .second_wide_half_out(s_out), .second_wide_half_oe(s_oe),
    .first_half_load_enable_n(ctl[5]), .second_half_load_enable_n(ctl[4]),
    .half_select_n(ctl[3]), .narrow_port_drive_enable_n(ctl[2]),
    .first_half_drive_enable_n(ctl[1]), .second_half_drive_enable_n(ctl[0]),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

  dram_side_model far_u (.first_word(w1), .second_word(w2), .first_oe(f_oe),
    .first_out(f_out), .second_oe(s_oe), .second_out(s_out), .first_level(l1),
    .second_level(l2));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [11:0] pick(input logic sel_n, input logic [11:0] a, b);
    return sel_n ? a : b;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Expectations use the levels sampled at the edge, before the design updates
  task automatic step(input logic [5:0] c, input logic [11:0] n, a, b);
    @(posedge core_clk);
    if (!ctl[5]) e1 = narrow_in;
    if (!ctl[4]) e2 = narrow_in;
    en = pick(ctl[3], l1, l2);
    eoe = rst ? 3'h0 : ~ctl[2:0];
    ctl <= c;
    narrow_word <= n;
    w1 <= a;
    w2 <= b;
    #1;
    check(32'(f_out), 32'(e1));
    check(32'(s_out), 32'(e2));
    check(32'(narrow_out), 32'(en));
    check(32'({narrow_oe, f_oe, s_oe}), 32'(eoe));
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    tally_and_finish();
  end

  initial begin
    // Drive enables held high and loads active through reset
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    #1;
    check(32'({narrow_oe, f_oe, s_oe}), 32'h0);
    step(6'h1f, 12'ha5c, 12'h111, 12'h222);
    step(6'h2f, 12'h3c1, 12'h333, 12'h444);
    step(6'h3f, 12'h0ff, 12'h555, 12'h666);
    step(6'h3f, 12'h0ee, 12'h777, 12'h888);
    check(32'({s_out, f_out}), 32'h003c_1a5c);
    for (int i = 0; i < 400; i++) begin
      seed = lfsr(seed);
      step(seed[5:0], seed[17:6], seed[29:18], {seed[31:30], seed[9:0]});
    end
    $display("pin traffic test done");
    step(6'h3b, 12'h000, 12'h5a3, 12'h0c6);
    step(6'h3b, 12'h000, 12'h5a3, 12'h0c6);
    apb(1'b0, 8'h00, 32'h0);
    check(rd, 32'h0);
    apb(1'b1, 8'h00, 32'h1);
    apb(1'b0, 8'h00, 32'h0);
    check(rd, 32'h1);
    repeat (40) @(posedge core_clk);
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b0, 8'h04, 32'h0);
    check(rd, 32'h0000_2013);
    check(32'(er), 32'h0);
    for (int i = 0; i < 32; i++) begin
      apb(1'b0, 8'h08, 32'h0);
      check(rd, 32'h0000_05a3);
    end
    apb(1'b0, 8'h04, 32'h0);
    check(rd, 32'h0000_0011);
    apb(1'b1, 8'h04, 32'h1);
    apb(1'b0, 8'h04, 32'h0);
    check(rd, 32'h0000_0010);
    apb(1'b0, 8'h08, 32'h0);
    check(rd, 32'h0);
    $display("capture log test done");
    apb(1'b0, 8'h0c, 32'h0);
    check({rd[30:0], er}, 32'h1);
    apb(1'b1, 8'h10, 32'h1);
    check(32'(er), 32'h1);
    $display("unmapped access test done");
    tally_and_finish();
  end
endmodule
